// ---- rtl/dsp_pkg.sv ----
// Package of constants and types for the display serial host port
package dsp_pkg;
   // ---------------------------------------------------------------
   // Interface mode strap codes
   // ---------------------------------------------------------------
   localparam logic [2:0] DSP_MODE_3LINE = 3'h0;
   localparam logic [2:0] DSP_MODE_4LINE = 3'h1;
   localparam logic [2:0] DSP_MODE_2LANE = 3'h2;
   // ---------------------------------------------------------------
   // Command codes that start a read or a memory write
   // ---------------------------------------------------------------
   localparam logic [7:0] DSP_CMD_RD_STAT_LO = 8'h0a;
   localparam logic [7:0] DSP_CMD_RD_STAT_HI = 8'h0f;
   localparam logic [7:0] DSP_CMD_RD_ID_ONE  = 8'hda;
   localparam logic [7:0] DSP_CMD_RD_ID_TWO  = 8'hdb;
   localparam logic [7:0] DSP_CMD_RD_ID_THR  = 8'hdc;
   localparam logic [7:0] DSP_CMD_RD_DISP_ID = 8'h04;
   localparam logic [7:0] DSP_CMD_RD_DISP_ST = 8'h09;
   localparam logic [7:0] DSP_CMD_MEM_WRITE  = 8'h2c;
   localparam logic [7:0] DSP_CMD_MEM_CONT   = 8'h3c;
   // ---------------------------------------------------------------
   // Read response lengths in bits
   // ---------------------------------------------------------------
   localparam logic [5:0] DSP_RD_LEN_BYTE = 6'h08;
   localparam logic [5:0] DSP_RD_LEN_ID   = 6'h18;
   localparam logic [5:0] DSP_RD_LEN_STAT = 6'h20;
   localparam int         DSP_FIFO_DEPTH  = 8;
   localparam int         DSP_WORD_W      = 10;

   // Word in the FIFO: flag, memory-write marker, byte
   typedef struct packed {
      logic       is_data;
      logic       is_mem;
      logic [7:0] byte_val;
   } dsp_word_t;

   typedef enum logic [3:0] {
      DSP_IDLE  = 4'h1,
      DSP_RECV  = 4'h2,
      DSP_TURN  = 4'h4,
      DSP_SEND  = 4'h8
   } dsp_state_t;
endpackage

// ---- rtl/dsp_stream_if.sv ----
// Interface carrying received words between the receiver and the FIFO
interface dsp_stream_if;
   import dsp_pkg::*;
   logic      valid;
   logic      ready;
   dsp_word_t data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface

// ---- rtl/dsp_fifo.sv ----
// Word FIFO with valid and ready on both sides
module dsp_fifo #(
   parameter int WIDTH = dsp_pkg::DSP_WORD_W,
   parameter int DEPTH = dsp_pkg::DSP_FIFO_DEPTH
) (
   input  wire logic             clock,
   input  wire logic             reset,
   dsp_stream_if.dst             wr,
   output logic                  rd_valid,
   input  wire logic             rd_ready,
   output logic [WIDTH-1:0]      rd_data
);
   import dsp_pkg::*;
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
   } dsp_fifo_st_t;

   dsp_fifo_st_t     st_r;
   dsp_fifo_st_t     st_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             full;
   logic             empty;
   logic             do_wr;
   logic             do_rd;

   assign full     = (st_r.wr_ptr[AW] != st_r.rd_ptr[AW]) &&
                     (st_r.wr_ptr[AW-1:0] == st_r.rd_ptr[AW-1:0]);
   assign empty    = st_r.wr_ptr == st_r.rd_ptr;
   assign wr.ready = !full;
   assign do_wr    = wr.valid && !full;
   assign do_rd    = rd_ready && !empty;
   assign rd_valid = !empty;
   assign rd_data  = mem[st_r.rd_ptr[AW-1:0]];

   always_comb begin
      st_nxt = st_r;
      if (do_wr) begin
         st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
      end
      if (do_rd) begin
         st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
      if (do_wr) begin
         mem[st_r.wr_ptr[AW-1:0]] <= WIDTH'(wr.data);
      end
   end
endmodule

// ---- rtl/dsp_host_port.sv ----
// Serial host command port: receiver, read responder and output FIFO
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module dsp_host_port (
   input  wire logic               clock,
   input  wire logic               reset,
   input  wire logic               hw_reset_n,
   input  wire logic [2:0]         interface_mode_straps,
   input  wire logic               serial_chip_select_n,
   input  wire logic               serial_clock_pin,
   input  wire logic               cmd_flag_serial_pin,
   input  wire logic               primary_data_lane_in,
   output logic                    primary_data_lane_out,
   output logic                    primary_data_lane_oe,
   output logic                    word_valid,
   input  wire logic               word_ready,
   output logic                    word_is_data,
   output logic                    word_is_mem,
   output logic [7:0]              word_byte,
   output logic                    overrun,
   input  wire logic [31:0]        read_value
);
   import dsp_pkg::*;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Every pin passes two flops; edges are found on the second stage
   logic [4:0] meta_r;
   logic [4:0] sync_r;
   logic [2:0] mode_meta_r;
   logic [2:0] mode_sync_r;
   logic       sclk_d_r;
   logic       csn_d_r;

   always_ff @(posedge clock) begin
      meta_r   <= {hw_reset_n, serial_chip_select_n, serial_clock_pin,
                   cmd_flag_serial_pin, primary_data_lane_in};
      sync_r   <= meta_r;
      mode_meta_r <= interface_mode_straps;
      mode_sync_r <= mode_meta_r;
      sclk_d_r <= sync_r[2];
      csn_d_r  <= sync_r[3];
   end

   logic hrst_n;
   logic csn;
   logic sclk;
   logic cmd_flag_pin;
   logic sda;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   assign hrst_n    = sync_r[4];
   assign csn       = sync_r[3];
   assign sclk      = sync_r[2];
   assign cmd_flag_pin       = sync_r[1];
   assign sda       = sync_r[0];
   assign sclk_rise = sclk && !sclk_d_r && !csn;
   assign sclk_fall = !sclk && sclk_d_r && !csn;
   assign cs_fall   = !csn && csn_d_r;

   // ---------------------------------------------------------------
   // Command length and mode decode
   // ---------------------------------------------------------------
   function automatic logic [5:0] rd_len(input logic [7:0] cmd);
      if (cmd >= DSP_CMD_RD_STAT_LO && cmd <= DSP_CMD_RD_STAT_HI) begin
         rd_len = DSP_RD_LEN_BYTE;
      end else if (cmd == DSP_CMD_RD_ID_ONE || cmd == DSP_CMD_RD_ID_TWO ||
                   cmd == DSP_CMD_RD_ID_THR) begin
         rd_len = DSP_RD_LEN_BYTE;
      end else if (cmd == DSP_CMD_RD_DISP_ID) begin
         rd_len = DSP_RD_LEN_ID;
      end else if (cmd == DSP_CMD_RD_DISP_ST) begin
         rd_len = DSP_RD_LEN_STAT;
      end else begin
         rd_len = 6'h00;
      end
   endfunction

   // Short responses are left-justified so bit 31 always leads the shifter
   function automatic logic [31:0] rd_align(input logic [5:0] len, input logic [31:0] val);
      if (len == DSP_RD_LEN_BYTE) begin
         rd_align = {val[7:0], 24'h000000};
      end else if (len == DSP_RD_LEN_ID) begin
         rd_align = {val[23:0], 8'h00};
      end else begin
         rd_align = val;
      end
   endfunction

   logic mode4;
   logic mode2;
   assign mode4 = mode_sync_r == DSP_MODE_4LINE;
   assign mode2 = mode_sync_r == DSP_MODE_2LANE;

   // ---------------------------------------------------------------
   // Receiver state
   // ---------------------------------------------------------------
   typedef struct packed {
      dsp_state_t  state;
      logic        flag;
      logic        have_flag;
      logic [7:0]  shreg;
      logic [3:0]  nbits;
      logic        mem_mode;
      logic [7:0]  cur_cmd;
      logic [5:0]  rd_left;
      logic [31:0] rd_shift;
      logic        out_bit;
      logic        oe;
      logic        push;
      dsp_word_t   word;
      logic        overrun;
   } dsp_rx_st_t;

   dsp_rx_st_t  st_r;
   dsp_rx_st_t  st_nxt;
   dsp_stream_if fifo_in ();
   logic [DSP_WORD_W-1:0] fifo_out;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.push = 1'b0;
      if (st_r.push && !fifo_in.ready) begin
         st_nxt.overrun = 1'b1;
      end
      if (csn) begin
         // Partial bits are thrown away; command context kept for pause
         st_nxt.state     = DSP_IDLE;
         st_nxt.nbits     = 4'h0;
         st_nxt.have_flag = 1'b0;
         st_nxt.oe        = 1'b0;
         st_nxt.rd_left   = 6'h00;
      end else begin
         unique case (st_r.state)
            DSP_IDLE: begin
               if (cs_fall || !csn) begin
                  st_nxt.state = DSP_RECV;
               end
            end
            DSP_RECV: begin
               if (sclk_rise) begin
                  if (!mode4 && !st_r.have_flag) begin
                     st_nxt.flag      = sda;
                     st_nxt.have_flag = 1'b1;
                  end else begin
                     if (mode2 && st_r.flag && st_r.mem_mode) begin
                        // Primary lane holds the upper bit of the pair
                        st_nxt.shreg = {st_r.shreg[5:0], sda, cmd_flag_pin};
                        st_nxt.nbits = st_r.nbits + 4'h2;
                     end else begin
                        st_nxt.shreg = {st_r.shreg[6:0], sda};
                        st_nxt.nbits = st_r.nbits + 4'h1;
                     end
                     if (mode4 && st_r.nbits == 4'h7) begin
                        st_nxt.flag = cmd_flag_pin;
                     end
                  end
               end
               if (st_r.nbits == 4'h8) begin
                  // Byte complete: next rising edge opens a new packet
                  st_nxt.nbits     = 4'h0;
                  st_nxt.have_flag = 1'b0;
                  st_nxt.push      = 1'b1;
                  st_nxt.word      = '{is_data: st_r.flag,
                                       is_mem: st_r.flag && st_r.mem_mode,
                                       byte_val: st_r.shreg};
                  if (!st_r.flag) begin
                     // New command closes any earlier parameter run
                     st_nxt.cur_cmd  = st_r.shreg;
                     st_nxt.mem_mode = st_r.shreg == DSP_CMD_MEM_WRITE ||
                                       st_r.shreg == DSP_CMD_MEM_CONT;
                     st_nxt.rd_left  = rd_len(st_r.shreg);
                     st_nxt.rd_shift = rd_align(rd_len(st_r.shreg), read_value);
                     if (rd_len(st_r.shreg) != 6'h00) begin
                        st_nxt.state = DSP_TURN;
                     end
                  end
                  // A data byte leaves cur_cmd and mem_mode for resume
               end
            end
            DSP_TURN: begin
               // Host has released the line by this falling edge
               if (sclk_fall) begin
                  st_nxt.oe       = 1'b1;
                  st_nxt.out_bit  = st_r.rd_shift[31];
                  st_nxt.rd_shift = {st_r.rd_shift[30:0], 1'b0};
                  st_nxt.state    = DSP_SEND;
               end
            end
            DSP_SEND: begin
               if (sclk_rise) begin
                  st_nxt.rd_left = st_r.rd_left - 6'h01;
               end
               if (sclk_fall) begin
                  if (st_r.rd_left == 6'h00) begin
                     st_nxt.oe = 1'b0;
                  end else begin
                     st_nxt.out_bit  = st_r.rd_shift[31];
                     st_nxt.rd_shift = {st_r.rd_shift[30:0], 1'b0};
                  end
               end
            end
            default: begin
               st_nxt.state = DSP_IDLE;
            end
         endcase
      end
      if (!hrst_n) begin
         // Hardware reset drops everything; memory mode is left, so the next data byte is not a memory write
         st_nxt = '0;
         st_nxt.state = DSP_IDLE;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st_r       <= '0;
         st_r.state <= DSP_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Output FIFO
   // ---------------------------------------------------------------
   // Back-pressure: a word arriving while full raises the sticky overrun
   assign fifo_in.valid = st_r.push;
   assign fifo_in.data  = st_r.word;

   // Registered output stage so every output comes from a flop
   logic       word_valid_hold;
   dsp_word_t  out_w_r;
   logic       out_v_r;
   assign word_valid_hold = out_v_r && !word_ready;

   // Pop exactly when the output stage loads, or a word would be shown twice
   logic fifo_valid;
   dsp_fifo #(
      .WIDTH (DSP_WORD_W),
      .DEPTH (DSP_FIFO_DEPTH)
   ) u_fifo (
      .clock    (clock),
      .reset    (reset),
      .wr       (fifo_in),
      .rd_valid (fifo_valid),
      .rd_ready (!word_valid_hold),
      .rd_data  (fifo_out)
   );

   always_ff @(posedge clock) begin
      if (reset) begin
         out_v_r <= 1'b0;
         out_w_r <= '0;
      end else if (!word_valid_hold) begin
         out_v_r <= fifo_valid;
         out_w_r <= dsp_word_t'(fifo_out);
      end
   end

   assign word_valid            = out_v_r;
   assign word_is_data          = out_w_r.is_data;
   assign word_is_mem           = out_w_r.is_mem;
   assign word_byte             = out_w_r.byte_val;
   assign overrun               = st_r.overrun;
   assign primary_data_lane_out = st_r.out_bit;
   assign primary_data_lane_oe  = st_r.oe;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_cs_idle;
      @(posedge clock) disable iff (reset) csn |=> st_r.state == DSP_IDLE && !st_r.oe;
   endproperty
   a_cs_idle: assert property (p_cs_idle) else $error("receiver active while deselected");

   property p_hw_reset;
      @(posedge clock) disable iff (reset) !hrst_n |=> st_r.nbits == 4'h0 && !st_r.mem_mode;
   endproperty
   a_hw_reset: assert property (p_hw_reset) else $error("hardware reset left state");

   property p_cmd_flag;
      @(posedge clock) disable iff (reset)
         st_r.push && !st_r.word.is_data |-> !st_r.word.is_mem;
   endproperty
   a_cmd_flag: assert property (p_cmd_flag) else $error("command routed to memory");

   property p_out_on_fall;
      @(posedge clock) disable iff (reset)
         $changed(st_r.out_bit) && st_r.oe |-> $past(sclk_fall);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall) else $error("read bit moved off falling edge");

   property p_no_drive_idle;
      @(posedge clock) disable iff (reset) st_r.oe |-> !csn || $past(!csn);
   endproperty
   a_no_drive_idle: assert property (p_no_drive_idle) else $error("line driven while deselected");

   property p_byte_push;
      @(posedge clock) disable iff (reset)
         st_r.nbits == 4'h8 && !csn && hrst_n |=> st_r.push && st_r.nbits == 4'h0;
   endproperty
   a_byte_push: assert property (p_byte_push) else $error("completed byte not pushed");

   property p_data_keeps_cmd;
      @(posedge clock) disable iff (reset)
         st_r.push && st_r.word.is_data |-> $stable(st_r.cur_cmd);
   endproperty
   a_data_keeps_cmd: assert property (p_data_keeps_cmd) else $error("data byte changed command");

   property p_turn_next;
      @(posedge clock) disable iff (reset)
         st_r.state == DSP_TURN && sclk_fall && !csn && hrst_n |=> st_r.oe;
   endproperty
   a_turn_next: assert property (p_turn_next) else $error("response not driven");

   property p_resp_len;
      @(posedge clock) disable iff (reset)
         st_r.state == DSP_SEND && st_r.rd_left == 6'h00 && sclk_fall && hrst_n |=> !st_r.oe;
   endproperty
   a_resp_len: assert property (p_resp_len) else $error("response ran past its length");
endmodule

// ---- verification/dsp_host_model.sv ----
// Behavioural host that drives the serial command link of the host port
module dsp_host_model (
   input  wire logic       clock,
   input  wire logic [2:0] mode,
   input  wire logic       dev_out,
   input  wire logic       dev_oe,
   output logic            sel_n,
   output logic            sclk,
   output logic            lane2,
   output logic            line_in
);
   import dsp_pkg::*;
   logic host_d;
   logic host_oe;
   logic l2_d;
   logic l2_oe;
   logic junk;
   // ---------------------------------------------------------------
   // Wire levels
   // ---------------------------------------------------------------
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      host_d = 1'b0;
      host_oe = 1'b0;
      l2_d = 1'b0;
      l2_oe = 1'b0;
      junk = 1'b0;
   end
   // A released lane toggles so that no stale value can pass for data
   always @(negedge clock) junk <= ~junk;
   assign line_in = dev_oe ? dev_out : (host_oe ? host_d : junk);
   assign lane2   = l2_oe ? l2_d : junk;
   // ---------------------------------------------------------------
   // Link cycles, 8 system clocks per serial bit, clock idle low
   // ---------------------------------------------------------------
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic bit_out(input logic d, input logic d2, input logic use2);
      @(negedge clock);
      sclk = 1'b0;
      host_d = d;
      host_oe = 1'b1;
      l2_d = d2;
      l2_oe = use2;
      wait_clk(4);
      sclk = 1'b1;
      wait_clk(3);
   endtask
   task automatic begin_frame(input logic lvl);
      @(negedge clock);
      sclk = lvl;
      wait_clk(4);
      sel_n = 1'b0;
      wait_clk(8);
   endtask
   task automatic end_frame();
      @(negedge clock);
      sclk = 1'b0;
      host_oe = 1'b0;
      l2_oe = 1'b0;
      wait_clk(4);
      sel_n = 1'b1;
      wait_clk(12);
   endtask
   // Sends the flag and the first nb bits of a byte
   task automatic send_byte(input logic flag, input logic [7:0] b, input int nb);
      if (mode == DSP_MODE_4LINE) begin
         for (int i = 7; i > 7 - nb; i--) bit_out(b[i], flag, 1'b1);
      end else begin
         bit_out(flag, 1'b0, 1'b0);
         for (int i = 7; i > 7 - nb; i--) bit_out(b[i], 1'b0, 1'b0);
      end
   endtask
   task automatic send_mem2(input logic [7:0] b);
      bit_out(1'b1, 1'b0, 1'b0);
      for (int i = 3; i >= 0; i--) bit_out(b[2*i+1], b[2*i], 1'b1);
   endtask
   task automatic read(input logic [7:0] cmd, input int n, output logic [31:0] q);
      send_byte(1'b0, cmd, 8);
      @(negedge clock);
      sclk = 1'b0;
      host_oe = 1'b0;
      q = 32'h0;
      for (int i = 0; i < n; i++) begin
         wait_clk(4);
         sclk = 1'b1;
         wait_clk(3);
         q = {q[30:0], line_in};
         @(negedge clock);
         sclk = 1'b0;
      end
   endtask
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench of the display serial host port
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dsp_pkg::*;
   typedef struct packed {
      logic [2:0] mode;
      logic       kind;
      logic       flag;
      logic [7:0] b;
      logic       mem;
   } dsp_row_t;
   localparam dsp_row_t ROWS [17] = '{
      '{3'h0, 1'b0, 1'b0, 8'h3a, 1'b0}, '{3'h0, 1'b0, 1'b1, 8'h81, 1'b0},
      '{3'h0, 1'b0, 1'b0, 8'h2c, 1'b0}, '{3'h0, 1'b0, 1'b1, 8'ha5, 1'b1},
      '{3'h0, 1'b0, 1'b1, 8'h5a, 1'b1}, '{3'h0, 1'b0, 1'b0, 8'h29, 1'b0},
      '{3'h0, 1'b0, 1'b1, 8'hc3, 1'b0}, '{3'h1, 1'b0, 1'b0, 8'h3a, 1'b0},
      '{3'h1, 1'b0, 1'b1, 8'h7e, 1'b0}, '{3'h1, 1'b0, 1'b0, 8'h3c, 1'b0},
      '{3'h1, 1'b0, 1'b1, 8'h96, 1'b1}, '{3'h1, 1'b0, 1'b0, 8'h29, 1'b0},
      '{3'h2, 1'b0, 1'b0, 8'h3a, 1'b0}, '{3'h2, 1'b0, 1'b1, 8'h81, 1'b0},
      '{3'h2, 1'b0, 1'b0, 8'h2c, 1'b0}, '{3'h2, 1'b1, 1'b1, 8'ha5, 1'b1},
      '{3'h2, 1'b1, 1'b1, 8'h3c, 1'b1}};
   localparam logic [7:0] RD_CODE [11] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f,
                                         8'hda, 8'hdb, 8'hdc, 8'h04, 8'h09};
   logic        clock, reset, hw_reset_n, word_ready, word_valid, word_is_data;
   logic        word_is_mem, overrun, sel_n, sclk, lane2, line_in, lane_out, lane_oe;
   logic [2:0]  straps;
   logic [7:0]  word_byte;
   logic [31:0] read_value, q;
   logic [9:0]  got_q [$];
   int          n_errors, samples_checked, n;
   // ---------------------------------------------------------------
   // Clock, instances and word collector
   // ---------------------------------------------------------------
   always #10 clock = ~clock;
   dsp_host_port dsp_host_port_inst (.clock(clock), .reset(reset), .hw_reset_n(hw_reset_n),
      .interface_mode_straps(straps), .serial_chip_select_n(sel_n),
      .serial_clock_pin(sclk), .cmd_flag_serial_pin(lane2), .primary_data_lane_in(line_in),
      .primary_data_lane_out(lane_out), .primary_data_lane_oe(lane_oe),
      .word_valid(word_valid), .word_ready(word_ready), .word_is_data(word_is_data),
      .word_is_mem(word_is_mem), .word_byte(word_byte), .overrun(overrun),
      .read_value(read_value));
   dsp_host_model dsp_host_model_inst (.clock(clock), .mode(straps), .dev_out(lane_out),
      .dev_oe(lane_oe), .sel_n(sel_n), .sclk(sclk), .lane2(lane2), .line_in(line_in));
   always @(posedge clock) begin
      if (word_valid === 1'b1 && word_ready === 1'b1) begin
         got_q.push_back({word_is_data, word_is_mem, word_byte});
      end
   end
   // ---------------------------------------------------------------
   // Checking tasks
   // ---------------------------------------------------------------
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bounded wait for one received word
   task automatic expect_word(input logic [9:0] exp);
      int k;
      k = 0;
      while (got_q.size() == 0 && k < 400) begin
         @(negedge clock);
         k++;
      end
      if (got_q.size() == 0) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen none expected %h", $time, exp);
         end_sim();
      end else begin
         check({22'h0, got_q.pop_front()}, {22'h0, exp});
      end
   endtask
   task automatic do_reset(input logic [2:0] m);
      @(negedge clock);
      reset = 1'b1;
      straps = m;
      repeat (16) @(negedge clock);
      reset = 1'b0;
      repeat (4) @(negedge clock);
      // Outputs must come out of reset low, the sticky loss flag too
      check({29'h0, word_valid, lane_oe, overrun}, 32'h0);
      got_q.delete();
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      clock = 1'b0;
      reset = 1'b1;
      hw_reset_n = 1'b1;
      straps = DSP_MODE_3LINE;
      word_ready = 1'b1;
      read_value = 32'hc35a_96e1;
      n_errors = 0;
      samples_checked = 0;
      do_reset(DSP_MODE_3LINE);
      // Each row in its own frame, so every word also crosses a pause
      foreach (ROWS[i]) begin
         if (ROWS[i].mode != straps) do_reset(ROWS[i].mode);
         dsp_host_model_inst.begin_frame(1'b0);
         if (ROWS[i].kind) dsp_host_model_inst.send_mem2(ROWS[i].b);
         else dsp_host_model_inst.send_byte(ROWS[i].flag, ROWS[i].b, 8);
         dsp_host_model_inst.end_frame();
         expect_word({ROWS[i].flag, ROWS[i].mem, ROWS[i].b});
      end
      for (int m = 0; m < 3; m++) begin
         do_reset(m[2:0]);
         foreach (RD_CODE[i]) begin
            n = (i < 9) ? 8 : ((i == 9) ? 24 : 32);
            read_value = {RD_CODE[i], 8'h5a ^ i[7:0], ~RD_CODE[i], 8'hc3 ^ m[7:0]};
            dsp_host_model_inst.begin_frame(1'b0);
            dsp_host_model_inst.read(RD_CODE[i], n, q);
            dsp_host_model_inst.end_frame();
            check(q, (n == 32) ? read_value : (read_value & ((32'h1 << n) - 32'h1)));
            check({31'h0, lane_oe}, 32'h0);
            got_q.delete();
         end
      end
      // Clock pulses with select high are ignored, then select falls with clock high
      do_reset(DSP_MODE_3LINE);
      for (int i = 0; i < 9; i++) dsp_host_model_inst.bit_out(i[0], 1'b0, 1'b0);
      dsp_host_model_inst.wait_clk(20);
      check(got_q.size(), 32'h0);
      dsp_host_model_inst.begin_frame(1'b1);
      dsp_host_model_inst.send_byte(1'b0, 8'h2c, 8);
      dsp_host_model_inst.end_frame();
      expect_word({2'b00, 8'h2c});
      // Select rises mid-byte: the partial byte is dropped and the next byte lands in memory context
      dsp_host_model_inst.begin_frame(1'b0);
      dsp_host_model_inst.send_byte(1'b1, 8'hff, 4);
      dsp_host_model_inst.end_frame();
      dsp_host_model_inst.begin_frame(1'b0);
      dsp_host_model_inst.send_byte(1'b1, 8'h96, 8);
      dsp_host_model_inst.end_frame();
      expect_word({2'b11, 8'h96});
      check(got_q.size(), 32'h0);
      // Hardware reset mid-byte drops bits and leaves memory mode
      dsp_host_model_inst.begin_frame(1'b0);
      dsp_host_model_inst.send_byte(1'b1, 8'h0f, 5);
      hw_reset_n = 1'b0;
      dsp_host_model_inst.wait_clk(8);
      hw_reset_n = 1'b1;
      dsp_host_model_inst.wait_clk(8);
      dsp_host_model_inst.end_frame();
      dsp_host_model_inst.begin_frame(1'b0);
      dsp_host_model_inst.send_byte(1'b1, 8'h69, 8);
      dsp_host_model_inst.end_frame();
      expect_word({2'b10, 8'h69});
      check(got_q.size(), 32'h0);
      // Back-to-back packets into a stalled consumer until the FIFO refuses
      word_ready = 1'b0;
      dsp_host_model_inst.begin_frame(1'b0);
      dsp_host_model_inst.send_byte(1'b0, 8'h2a, 8);
      for (int i = 0; i < 11; i++) dsp_host_model_inst.send_byte(1'b1, 8'h10 + i[7:0], 8);
      dsp_host_model_inst.end_frame();
      check({31'h0, overrun}, 32'h1);
      word_ready = 1'b1;
      expect_word({2'b00, 8'h2a});
      for (int i = 0; i < 8; i++) expect_word({2'b10, 8'h10 + i[7:0]});
      dsp_host_model_inst.wait_clk(30);
      check({31'h0, word_valid}, 32'h0);
      do_reset(DSP_MODE_3LINE);
      end_sim();
   end
endmodule
